// ==== common/vcc_pkg.sv ====
package vcc_pkg;
	// ----------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------
	localparam logic [11:0] IDX_ENCODE_PARAM_ONE = 12'hC56;
	localparam logic [11:0] IDX_ENCODE_PARAM_TWO = 12'hC58;
	localparam logic [11:0] IDX_INTRA_TOLERANCE = 12'hC5A;
	localparam logic [11:0] IDX_FOUR_VECTOR_TOLERANCE = 12'hC5C;
	localparam logic [11:0] IDX_ZERO_VECTOR_TOLERANCE = 12'hC5E;
	localparam logic [11:0] IDX_SAFE_CFG_ONE = 12'hC60;
	localparam logic [11:0] IDX_SAFE_CFG_TWO = 12'hC62;
	localparam logic [11:0] IDX_SAFE_CFG_THREE = 12'hC64;
	localparam logic [11:0] IDX_ENCODE_IRQ_ENABLE = 12'hC66;
	localparam logic [11:0] IDX_ENCODE_CTRL = 12'hC68;
	localparam logic [11:0] IDX_BITSTREAM_READ_SIZE = 12'hC6A;
	localparam logic [11:0] IDX_FIRE_COMMAND = 12'hC6C;
	localparam logic [11:0] IDX_DEC_BUF0_LUMA_LO = 12'hC6E;
	localparam logic [11:0] IDX_DEC_BUF0_LUMA_HI = 12'hC70;
	localparam logic [11:0] IDX_DEC_BUF0_CB_LO = 12'hC72;
	localparam logic [11:0] IDX_DEC_BUF0_CB_HI = 12'hC74;
	localparam logic [11:0] IDX_DEC_BUF0_CR_LO = 12'hC76;
	localparam logic [11:0] IDX_DEC_BUF0_CR_HI = 12'hC78;
	localparam logic [11:0] IDX_DEC_BUF1_LUMA_LO = 12'hC7A;
	localparam logic [11:0] IDX_DEC_BUF1_LUMA_HI = 12'hC7C;
	localparam logic [11:0] IDX_DEC_BUF1_CB_LO = 12'hC7E;
	localparam logic [11:0] IDX_DEC_BUF1_CB_HI = 12'hC80;
	localparam logic [11:0] IDX_DEC_BUF1_CR_LO = 12'hC82;
	localparam logic [11:0] IDX_DEC_BUF1_CR_HI = 12'hC84;
	localparam logic [11:0] IDX_DEC_BUF2_LUMA_LO = 12'hC86;
	localparam logic [11:0] IDX_DEC_BUF2_LUMA_HI = 12'hC88;
	localparam logic [11:0] IDX_DEC_BUF2_CB_LO = 12'hC8A;
	localparam logic [11:0] IDX_DEC_BUF2_CB_HI = 12'hC8C;
	localparam logic [11:0] IDX_DEC_BUF2_CR_LO = 12'hC8E;
	localparam logic [11:0] IDX_DEC_BUF2_CR_HI = 12'hC90;
	localparam logic [11:0] IDX_DECODE_WIDTH_PITCH = 12'hC92;
	localparam logic [11:0] IDX_DECODE_HEIGHT_PITCH = 12'hC94;
	localparam logic [11:0] IDX_DECODE_SPECIAL_CTRL = 12'hC96;
	localparam int NUM_SLOTS = 33;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	// ----------------------------------------
	// field positions, codes and masks
	// ----------------------------------------
	localparam int SHORT_HDR_BIT = 0;
	localparam int KEY_PERIOD_LSB = 7;
	localparam int SUBPIX_BIT = 6;
	localparam int FOUR_MV_BIT = 5;
	localparam int RESTRICT_MV_BIT = 4;
	localparam int DC_THR_LSB = 1;
	localparam int QP_TRIG_BIT = 0;
	localparam int LARGE_PIC_BIT = 15;
	localparam int MB_NUM_LSB = 11;
	localparam int SKIP_NUM_LSB = 5;
	localparam int MAX_MB_LSB = 4;
	localparam int GATE_LSB = 8;
	localparam int HDR_CLR_BIT = 0;
	localparam int PIC_TYPE_BIT = 8;
	localparam int FIRE_QP_LSB = 3;
	localparam int FORCE_REF_BIT = 2;
	localparam int PITCH_LSB = 7;
	localparam int TC_BITS_LSB = 8;
	localparam int HALF_RATE_BIT = 6;
	localparam int SKIP_ONE_BIT = 5;
	localparam int ADD_ONE_BIT = 4;
	localparam int DEBLOCK_OFF_BIT = 3;
	localparam int DEC_SHORT_BIT = 2;
	localparam int CAP_IRQ_BIT = 1;
	localparam logic [1:0] TRIG_ISP = 2'h0;
	localparam logic [1:0] TRIG_CMD = 2'h1;
	localparam logic [1:0] TRIG_STOP = 2'h2;
	localparam logic [3:0] DBG_ARBITER = 4'h0;
	localparam logic [3:0] DBG_ME0 = 4'h1;
	localparam logic [3:0] DBG_ME1 = 4'h2;
	localparam logic [3:0] DBG_VLC = 4'h3;
	localparam logic [3:0] DBG_TC0 = 4'h4;
	localparam logic [2:0] DC_THR_ALL_DC = 3'h0;
	localparam logic [2:0] DC_THR_ALL_AC = 3'h7;
	localparam logic [4:0] DC_QP_BASE = 5'h0B;
	localparam logic [15:0] MASK_ALL = 16'hFFFF;
	localparam logic [15:0] MASK_TOL = 16'h0FFF;
	localparam logic [15:0] MASK_BIT0 = 16'h0001;
	localparam logic [15:0] MASK_SAFE3 = 16'h0703;
	localparam logic [15:0] MASK_IRQ = 16'h000F;
	localparam logic [15:0] MASK_FIRE = 16'h01FF;
	localparam logic [15:0] MASK_ADDR_HI = 16'h003F;
	localparam logic [15:0] MASK_GEOM = 16'hFFBF;
	localparam logic [15:0] MASK_SPECIAL_WR = 16'h1F4E;
	localparam logic [15:0] MASK_SPECIAL_RD = 16'h1F0E;
	typedef enum logic [1:0] {VCC_AHB_IDLE, VCC_AHB_WR, VCC_AHB_RD_WAIT, VCC_AHB_RD_DONE} vcc_ahb_st_t;
endpackage : vcc_pkg

// ==== rtl/vcc_ahb_front.sv ====
`timescale 1ns/100ps
`default_nettype none
module vcc_ahb_front (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wr_en,
	output logic [5:0] slot,
	output logic [15:0] wr_data,
	input wire logic [15:0] rd_data
);
	typedef struct packed {
		vcc_pkg::vcc_ahb_st_t st;
		logic [5:0] slot;
		logic hit;
		logic [31:0] rdata;
	} vcc_front_t;
	vcc_front_t s_r, s_nxt;
	logic accept;
	logic [11:0] idx;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// only word-aligned indices inside the bank hit; every other address answers okay with zero
	assign idx = haddr[13:2];
	assign accept = hsel & htrans[1] & hready;

	// reads take one wait state so a read right after a write sees the new value
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			vcc_pkg::VCC_AHB_RD_WAIT: begin
				s_nxt.st = vcc_pkg::VCC_AHB_RD_DONE;
				s_nxt.rdata = s_r.hit ? {16'h0000, rd_data} : 32'h00000000;
			end
			default: begin
				if (accept) begin
					s_nxt.st = hwrite ? vcc_pkg::VCC_AHB_WR : vcc_pkg::VCC_AHB_RD_WAIT;
					s_nxt.hit = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2)
						&& (idx >= vcc_pkg::IDX_ENCODE_PARAM_ONE) && (idx <= vcc_pkg::IDX_DECODE_SPECIAL_CTRL)
						&& (idx[0] == vcc_pkg::IDX_ENCODE_PARAM_ONE[0]);
					s_nxt.slot = 6'((idx - vcc_pkg::IDX_ENCODE_PARAM_ONE) >> 1);
				end else begin
					s_nxt.st = vcc_pkg::VCC_AHB_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hreadyout = (s_r.st != vcc_pkg::VCC_AHB_RD_WAIT);
	assign hresp = 1'b0;
	assign hrdata = s_r.rdata;
	assign wr_en = (s_r.st == vcc_pkg::VCC_AHB_WR) & s_r.hit;
	assign slot = s_r.slot;
	assign wr_data = hwdata[15:0]; // upper half of the word is dropped
endmodule : vcc_ahb_front
`default_nettype wire

// ==== rtl/vcc_ctrl_regs.sv ====
// Behaviour
// - key frame inserted every period set in bits 15:7 of parameter two
// - threshold 0 all DC VLC, 7 all AC, else switch at Qp 13..23
// - quantiser trigger 0: microcontroller supplies quantiser; 1: fire command value
// - encoder limits bits per macroblock to the twelve-bit maximum field
// - debug select routes arbiter, motion estimators, VLC or transform zero
// - three gating bits: 0 frame-level, 1 macroblock-level clock gating
// - two-bit field gives number of shared image-processor frame buffers
// - encode interrupt raised only for causes whose enable bit is set
// - writing 1 to clear bit clears header buffer flag; 0 does nothing
// - trigger mode: 00 image processor, 01 command, 10 stop, 11 reserved
// - picture type honoured only in command trigger mode
// - fire command quantiser 1..31 used only when trigger bit is 1
// - forced refresh in image-processor mode makes intra frame, restarts counter
// - three decode buffers hold 22-bit Y, U, V bases split low/high
// - decode geometry: nine-bit pitches, six-bit width and height fields
// - write-only half-rate, skip-one and add-one bits act on written 1
// - deblocking filter on at 0, bypassed at 1
// - special bit 2 enables short header decode, bit 1 capture interrupt
// - short header flag makes encoder output H.263-compatible bitstream
`timescale 1ns/100ps
`default_nettype none
module vcc_ctrl_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [4:0] running_qp,
	input wire logic [4:0] microcontroller_qp,
	input wire logic hdr_buf_full,
	input wire logic vlc_buf_full,
	input wire logic enc_seq_done,
	input wire logic enc_frame_done,
	input wire logic [15:0] dbg_arbiter,
	input wire logic [15:0] dbg_motion_est0,
	input wire logic [15:0] dbg_motion_est1,
	input wire logic [15:0] dbg_vlc,
	input wire logic [15:0] dbg_transform0,
	output logic encode_irq,
	output logic enc_short_header,
	output logic [8:0] key_frame_period,
	output logic subpixel_en,
	output logic four_mv_en,
	output logic restricted_mv_en,
	output logic intra_ac_vlc,
	output logic [4:0] quantiser,
	output logic [11:0] intra_tolerance,
	output logic [11:0] four_vector_tolerance,
	output logic [11:0] zero_vector_tolerance,
	output logic large_picture,
	output logic [3:0] mb_bit_num,
	output logic [5:0] skip_frame_num,
	output logic [4:0] gob_increment,
	output logic [11:0] max_macroblock_bits,
	output logic [15:0] debug_info,
	output logic motion_est_clock_mb_gate,
	output logic transform_clock_mb_gate,
	output logic entropy_coder_clock_mb_gate,
	output logic [1:0] shared_buf_count,
	output logic hdr_flag_clear,
	output logic enc_run_isp,
	output logic enc_run_cmd,
	output logic enc_stop,
	output logic cmd_picture_type,
	output logic force_refresh,
	output logic [15:0] bitstream_read_size,
	output logic [21:0] luma_base_buf_zero,
	output logic [21:0] cb_base_buf_zero,
	output logic [21:0] cr_base_buf_zero,
	output logic [21:0] luma_base_buf_one,
	output logic [21:0] cb_base_buf_one,
	output logic [21:0] cr_base_buf_one,
	output logic [21:0] luma_base_buf_two,
	output logic [21:0] cb_base_buf_two,
	output logic [21:0] cr_base_buf_two,
	output logic [8:0] decode_luma_stride,
	output logic [5:0] decode_picture_width,
	output logic [8:0] decode_chroma_stride,
	output logic [5:0] decode_picture_height,
	output logic [4:0] dec_time_code_bits,
	output logic half_rate_en,
	output logic skip_one_frame,
	output logic add_one_frame,
	output logic deblock_en,
	output logic dec_short_header_en,
	output logic capture_irq_en
);
	// ----------------------------------------
	// slot numbers used by name
	// ----------------------------------------
	localparam logic [5:0] S_P1 = 6'h00;
	localparam logic [5:0] S_P2 = 6'h01;
	localparam logic [5:0] S_TOL_I = 6'h02;
	localparam logic [5:0] S_TOL_F = 6'h03;
	localparam logic [5:0] S_TOL_Z = 6'h04;
	localparam logic [5:0] S_SAFE1 = 6'h05;
	localparam logic [5:0] S_SAFE2 = 6'h06;
	localparam logic [5:0] S_SAFE3 = 6'h07;
	localparam logic [5:0] S_IRQ = 6'h08;
	localparam logic [5:0] S_CTRL = 6'h09;
	localparam logic [5:0] S_RDSZ = 6'h0A;
	localparam logic [5:0] S_FIRE = 6'h0B;
	localparam logic [5:0] S_BUF = 6'h0C;
	localparam logic [5:0] S_WID = 6'h1E;
	localparam logic [5:0] S_HGT = 6'h1F;
	localparam logic [5:0] S_SPEC = 6'h20;

	typedef struct packed {
		logic [vcc_pkg::NUM_SLOTS-1:0][15:0] regs;
		logic hdr_clr;
		logic skip1;
		logic add1;
		logic force_ref;
		logic half_rate;
		logic ac_vlc;
		logic [4:0] qp;
		logic [15:0] dbg;
	} vcc_regs_t;
	vcc_regs_t s_r, s_nxt;

	logic wr_en;
	logic [5:0] slot;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic use_ac;

	// ----------------------------------------
	// masks and field helpers
	// ----------------------------------------
	// writable bits of each slot; reserved bits never store, so they read zero
	function automatic logic [15:0] wmask(input logic [5:0] sl);
		if (sl == S_P1) begin
			wmask = vcc_pkg::MASK_BIT0;
		end else if (sl >= S_TOL_I && sl <= S_TOL_Z) begin
			wmask = vcc_pkg::MASK_TOL;
		end else if (sl == S_SAFE3) begin
			wmask = vcc_pkg::MASK_SAFE3;
		end else if (sl == S_IRQ) begin
			wmask = vcc_pkg::MASK_IRQ;
		end else if (sl == S_CTRL) begin
			wmask = 16'h0000;
		end else if (sl == S_FIRE) begin
			wmask = vcc_pkg::MASK_FIRE;
		end else if (sl >= S_BUF && sl < S_WID) begin
			wmask = sl[0] ? vcc_pkg::MASK_ADDR_HI : vcc_pkg::MASK_ALL;
		end else if (sl == S_WID || sl == S_HGT) begin
			wmask = vcc_pkg::MASK_GEOM;
		end else if (sl == S_SPEC) begin
			wmask = vcc_pkg::MASK_SPECIAL_WR;
		end else if (sl < 6'(vcc_pkg::NUM_SLOTS)) begin
			wmask = vcc_pkg::MASK_ALL;
		end else begin
			wmask = 16'h0000;
		end
	endfunction : wmask

	// joins the low and high halves of one decode base address
	function automatic logic [21:0] base_of(input vcc_regs_t st, input int k);
		base_of = {st.regs[S_BUF + 6'(2 * k + 1)][5:0], st.regs[S_BUF + 6'(2 * k)]};
	endfunction : base_of

	// ----------------------------------------
	// bus front and threshold decoder
	// ----------------------------------------
	vcc_ahb_front u_front (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.slot(slot),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	vcc_vlc_select u_vlc_sel (
		.dc_thr(s_r.regs[S_P2][vcc_pkg::DC_THR_LSB +: 3]),
		.running_qp(running_qp),
		.use_ac_vlc(use_ac)
	);

	// write-only half-rate, skip and add bits are left out of the read view
	always_comb begin
		rd_data = 16'h0000;
		if (slot < 6'(vcc_pkg::NUM_SLOTS)) begin
			rd_data = s_r.regs[slot] & wmask(slot);
		end
		if (slot == S_SPEC) begin
			rd_data = s_r.regs[S_SPEC] & vcc_pkg::MASK_SPECIAL_RD;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.hdr_clr = 1'b0;
		s_nxt.skip1 = 1'b0;
		s_nxt.add1 = 1'b0;
		s_nxt.force_ref = 1'b0;
		if (wr_en && slot < 6'(vcc_pkg::NUM_SLOTS)) begin
			s_nxt.regs[slot] = wr_data & wmask(slot);
		end
		// a clear command is a pulse; writing 0 does nothing
		if (wr_en && slot == S_CTRL) begin
			s_nxt.hdr_clr = wr_data[vcc_pkg::HDR_CLR_BIT];
		end
		if (wr_en && slot == S_SPEC) begin
			s_nxt.half_rate = wr_data[vcc_pkg::HALF_RATE_BIT];
			s_nxt.skip1 = wr_data[vcc_pkg::SKIP_ONE_BIT];
			s_nxt.add1 = wr_data[vcc_pkg::ADD_ONE_BIT];
		end
		// the mode written in the same word decides, so one write can switch and refresh
		if (wr_en && slot == S_FIRE) begin
			s_nxt.force_ref = wr_data[vcc_pkg::FORCE_REF_BIT] && (wr_data[1:0] == vcc_pkg::TRIG_ISP);
		end
		s_nxt.ac_vlc = use_ac;
		// quantiser source follows the trigger bit
		if (s_r.regs[S_P2][vcc_pkg::QP_TRIG_BIT]) begin
			s_nxt.qp = s_r.regs[S_FIRE][vcc_pkg::FIRE_QP_LSB +: 5];
		end else begin
			s_nxt.qp = microcontroller_qp;
		end
		// unused select codes show zero rather than a stale source
		unique case (s_r.regs[S_SAFE2][3:0])
			vcc_pkg::DBG_ARBITER: s_nxt.dbg = dbg_arbiter;
			vcc_pkg::DBG_ME0: s_nxt.dbg = dbg_motion_est0;
			vcc_pkg::DBG_ME1: s_nxt.dbg = dbg_motion_est1;
			vcc_pkg::DBG_VLC: s_nxt.dbg = dbg_vlc;
			vcc_pkg::DBG_TC0: s_nxt.dbg = dbg_transform0;
			default: s_nxt.dbg = 16'h0000;
		endcase
	end

	// every register clears to the reset value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// encoder controls
	// ----------------------------------------
	assign enc_short_header = s_r.regs[S_P1][vcc_pkg::SHORT_HDR_BIT];
	assign key_frame_period = s_r.regs[S_P2][vcc_pkg::KEY_PERIOD_LSB +: 9];
	assign subpixel_en = s_r.regs[S_P2][vcc_pkg::SUBPIX_BIT];
	// short header consistency is left to software; no hardware override
	assign four_mv_en = s_r.regs[S_P2][vcc_pkg::FOUR_MV_BIT];
	assign restricted_mv_en = s_r.regs[S_P2][vcc_pkg::RESTRICT_MV_BIT];
	assign intra_ac_vlc = s_r.ac_vlc;
	assign quantiser = s_r.qp;
	assign intra_tolerance = s_r.regs[S_TOL_I][11:0];
	assign four_vector_tolerance = s_r.regs[S_TOL_F][11:0];
	assign zero_vector_tolerance = s_r.regs[S_TOL_Z][11:0];
	assign large_picture = s_r.regs[S_SAFE1][vcc_pkg::LARGE_PIC_BIT];
	assign mb_bit_num = s_r.regs[S_SAFE1][vcc_pkg::MB_NUM_LSB +: 4];
	assign skip_frame_num = s_r.regs[S_SAFE1][vcc_pkg::SKIP_NUM_LSB +: 6];
	assign gob_increment = s_r.regs[S_SAFE1][4:0];
	assign max_macroblock_bits = s_r.regs[S_SAFE2][vcc_pkg::MAX_MB_LSB +: 12];
	assign debug_info = s_r.dbg;
	assign motion_est_clock_mb_gate = s_r.regs[S_SAFE3][vcc_pkg::GATE_LSB];
	assign transform_clock_mb_gate = s_r.regs[S_SAFE3][vcc_pkg::GATE_LSB + 1];
	assign entropy_coder_clock_mb_gate = s_r.regs[S_SAFE3][vcc_pkg::GATE_LSB + 2];
	assign shared_buf_count = s_r.regs[S_SAFE3][1:0];

	// engine flags pass only where their enable bit is set
	assign encode_irq = |({hdr_buf_full, vlc_buf_full, enc_seq_done, enc_frame_done} & s_r.regs[S_IRQ][3:0]);
	assign hdr_flag_clear = s_r.hdr_clr;

	// reserved mode 11 starts nothing
	assign enc_run_isp = (s_r.regs[S_FIRE][1:0] == vcc_pkg::TRIG_ISP);
	assign enc_run_cmd = (s_r.regs[S_FIRE][1:0] == vcc_pkg::TRIG_CMD);
	assign enc_stop = (s_r.regs[S_FIRE][1:0] == vcc_pkg::TRIG_STOP);
	assign cmd_picture_type = s_r.regs[S_FIRE][vcc_pkg::PIC_TYPE_BIT] & enc_run_cmd;
	assign force_refresh = s_r.force_ref;
	assign bitstream_read_size = s_r.regs[S_RDSZ];

	// ----------------------------------------
	// decoder controls
	// ----------------------------------------
	assign luma_base_buf_zero = base_of(s_r, 0);
	assign cb_base_buf_zero = base_of(s_r, 1);
	assign cr_base_buf_zero = base_of(s_r, 2);
	assign luma_base_buf_one = base_of(s_r, 3);
	assign cb_base_buf_one = base_of(s_r, 4);
	assign cr_base_buf_one = base_of(s_r, 5);
	assign luma_base_buf_two = base_of(s_r, 6);
	assign cb_base_buf_two = base_of(s_r, 7);
	assign cr_base_buf_two = base_of(s_r, 8);
	// sizes are passed as written; multiples of 16 are the caller's job
	assign decode_luma_stride = s_r.regs[S_WID][vcc_pkg::PITCH_LSB +: 9];
	assign decode_picture_width = s_r.regs[S_WID][5:0];
	assign decode_chroma_stride = s_r.regs[S_HGT][vcc_pkg::PITCH_LSB +: 9];
	assign decode_picture_height = s_r.regs[S_HGT][5:0];
	assign dec_time_code_bits = s_r.regs[S_SPEC][vcc_pkg::TC_BITS_LSB +: 5];
	assign half_rate_en = s_r.half_rate;
	assign skip_one_frame = s_r.skip1;
	assign add_one_frame = s_r.add1;
	assign deblock_en = ~s_r.regs[S_SPEC][vcc_pkg::DEBLOCK_OFF_BIT];
	assign dec_short_header_en = s_r.regs[S_SPEC][vcc_pkg::DEC_SHORT_BIT];
	assign capture_irq_en = s_r.regs[S_SPEC][vcc_pkg::CAP_IRQ_BIT];
endmodule : vcc_ctrl_regs
`default_nettype wire

// ==== rtl/vcc_vlc_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module vcc_vlc_select (
	input wire logic [2:0] dc_thr,
	input wire logic [4:0] running_qp,
	output logic use_ac_vlc
);
	logic [4:0] switch_qp;

	// ----------------------------------------
	// switch point 13,15..23 for codes 1..6
	// ----------------------------------------
	assign switch_qp = 5'(vcc_pkg::DC_QP_BASE + {1'b0, dc_thr, 1'b0});

	always_comb begin
		if (dc_thr == vcc_pkg::DC_THR_ALL_DC) begin
			use_ac_vlc = 1'b0;
		end else if (dc_thr == vcc_pkg::DC_THR_ALL_AC) begin
			use_ac_vlc = 1'b1;
		end else begin
			use_ac_vlc = (running_qp >= switch_qp);
		end
	end
endmodule : vcc_vlc_select
`default_nettype wire

// ==== tb/vcc_ctrl_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module vcc_ctrl_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic encode_irq,
	input wire logic hdr_buf_full,
	input wire logic vlc_buf_full,
	input wire logic enc_seq_done,
	input wire logic enc_frame_done,
	input wire logic enc_run_isp,
	input wire logic enc_run_cmd,
	input wire logic enc_stop,
	input wire logic cmd_picture_type,
	input wire logic hdr_flag_clear,
	input wire logic force_refresh
);
	// ----------------------------------------
	// bus timing and output relations
	// ----------------------------------------
	logic wr_q;
	// remembers a taken write so that pulses can be traced to it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= hsel && htrans[1] && hready && hwrite;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	AST_RD_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=> rd_wait_s)
		else $error("read wait wrong");
	AST_WR_NOWAIT: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write waited");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("error response");
	AST_IRQ_CAUSE: assert property (encode_irq |-> hdr_buf_full || vlc_buf_full || enc_seq_done || enc_frame_done)
		else $error("irq without cause");
	AST_MODE_ONE: assert property ($onehot0({enc_run_isp, enc_run_cmd, enc_stop}))
		else $error("two modes at once");
	AST_PIC_TYPE: assert property (cmd_picture_type |-> enc_run_cmd)
		else $error("picture type outside command mode");
	AST_CLR_PULSE: assert property (hdr_flag_clear |-> $past(wr_q))
		else $error("clear without write");
	AST_REFRESH: assert property (force_refresh |-> $past(wr_q) && enc_run_isp)
		else $error("refresh outside image mode");
endmodule : vcc_ctrl_chk
bind vcc_ctrl_regs vcc_ctrl_chk u_chk (.*);
`default_nettype wire

// ==== tb/vcc_engine_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module vcc_engine_model (
	input wire logic [3:0] cause_sel,
	input wire logic [4:0] qp_sel,
	output logic [4:0] running_qp,
	output logic [4:0] microcontroller_qp,
	output logic hdr_buf_full,
	output logic vlc_buf_full,
	output logic enc_seq_done,
	output logic enc_frame_done,
	output logic [15:0] dbg_arbiter,
	output logic [15:0] dbg_motion_est0,
	output logic [15:0] dbg_motion_est1,
	output logic [15:0] dbg_vlc,
	output logic [15:0] dbg_transform0
);
	// ----------------------------------------
	// engine side stand-in
	// ----------------------------------------
	// distinct debug words so a wrong route shows
	assign dbg_arbiter = 16'hA000;
	assign dbg_motion_est0 = 16'hA001;
	assign dbg_motion_est1 = 16'hA002;
	assign dbg_vlc = 16'hA003;
	assign dbg_transform0 = 16'hA004;
	// fixed rate-control answer, unlike any fire value used
	assign microcontroller_qp = 5'h09;
	assign running_qp = qp_sel;
	assign {hdr_buf_full, vlc_buf_full, enc_seq_done, enc_frame_done} = cause_sel;
endmodule : vcc_engine_model
`default_nettype wire

// ==== tb/video_codec_control_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module video_codec_control_regs_tb;
	// ----------------------------------------
	// bus master, engine stand-in and checks
	// ----------------------------------------
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [3:0] cause_sel = 4'h0;
	logic [4:0] qp_sel = 5'h00;
	logic [15:0] rv;
	int mismatches = 0, tests_run = 0;
	wire logic hready, hreadyout, hresp, encode_irq, enc_short_header, subpixel_en, four_mv_en, restricted_mv_en;
	wire logic intra_ac_vlc, large_picture, motion_est_clock_mb_gate, transform_clock_mb_gate;
	wire logic entropy_coder_clock_mb_gate, hdr_flag_clear, enc_run_isp, enc_run_cmd, enc_stop, cmd_picture_type;
	wire logic force_refresh, half_rate_en, skip_one_frame, add_one_frame, deblock_en, dec_short_header_en;
	wire logic capture_irq_en, hdr_buf_full, vlc_buf_full, enc_seq_done, enc_frame_done;
	wire logic [31:0] hrdata;
	wire logic [1:0] shared_buf_count;
	wire logic [3:0] mb_bit_num;
	wire logic [4:0] quantiser, gob_increment, dec_time_code_bits, running_qp, microcontroller_qp;
	wire logic [5:0] skip_frame_num, decode_picture_width, decode_picture_height;
	wire logic [8:0] key_frame_period, decode_luma_stride, decode_chroma_stride;
	wire logic [11:0] intra_tolerance, four_vector_tolerance, zero_vector_tolerance, max_macroblock_bits;
	wire logic [15:0] debug_info, bitstream_read_size, dbg_arbiter, dbg_motion_est0, dbg_motion_est1;
	wire logic [15:0] dbg_vlc, dbg_transform0;
	wire logic [21:0] luma_base_buf_zero, cb_base_buf_zero, cr_base_buf_zero, luma_base_buf_one, cb_base_buf_one;
	wire logic [21:0] cr_base_buf_one, luma_base_buf_two, cb_base_buf_two, cr_base_buf_two;
	// index beside the readback expected after writing all ones
	logic [27:0] rows [12] = '{{12'hC58, 16'hFFFF}, {12'hC5A, 16'h0FFF}, {12'hC60, 16'hFFFF},
		{12'hC64, 16'h0703}, {12'hC66, 16'h000F}, {12'hC68, 16'h0000}, {12'hC6C, 16'h01FF},
		{12'hC90, 16'h003F}, {12'hC94, 16'hFFBF}, {12'hC96, 16'h1F0E}, {12'hC98, 16'h0000}, {12'hC59, 16'h0000}};
	assign hready = hreadyout;
	vcc_ctrl_regs dut (.*);
	vcc_engine_model eng (.*);
	// free-running bus clock
	initial begin
		forever #10 hclk = ~hclk;
	end
	// one whole single transfer; read data lands in rv
	task automatic bus(input logic w, input logic [11:0] i, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {18'h0, i, 2'h0};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		rv = hrdata[15:0];
		#1;
	endtask : bus
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", s, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// cuts a hang short; the whole run needs a few hundred cycles
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chk("deblock", 32'(deblock_en), 32'h1);
		foreach (rows[n]) begin
			bus(1'b0, rows[n][27:16], 16'h0);
			chk("reset", 32'(rv), 32'h0);
			bus(1'b1, rows[n][27:16], 16'hFFFF);
			bus(1'b0, rows[n][27:16], 16'h0);
			chk("mask", 32'(rv), 32'(rows[n][15:0]));
		end
		bus(1'b1, 12'hC7E, 16'h1234);
		bus(1'b1, 12'hC80, 16'hFFD5);
		chk("cb1", 32'(cb_base_buf_one), 32'h151234);
		for (int c = 0; c < 6; c++) begin
			bus(1'b1, 12'hC62, 16'h7080 | 16'(c));
			@(posedge hclk);
			#1;
			chk("dbg", 32'(debug_info), (c < 5) ? 32'hA000 + 32'(c) : 32'h0);
		end
		chk("mbmax", 32'(max_macroblock_bits), 32'h708);
		for (int t = 0; t < 8; t++) begin
			for (int k = 0; k < 2; k++) begin
				qp_sel <= (t == 0) ? 5'h1F : (t == 7) ? 5'h00 : 5'(10 + 2 * t + k);
				bus(1'b1, 12'hC58, 16'hFF80 | 16'(2 * t));
				@(posedge hclk);
				#1;
				chk("acvlc", 32'(intra_ac_vlc), 32'(t == 7 || (t != 0 && k == 1)));
			end
		end
		chk("key", 32'(key_frame_period), 32'h1FF);
		chk("mq", 32'(quantiser), 32'h09);
		bus(1'b1, 12'hC6C, 16'h00FD);
		chk("nofr", 32'(force_refresh), 32'h0);
		bus(1'b1, 12'hC58, 16'h0001);
		@(posedge hclk);
		#1;
		chk("fq", 32'(quantiser), 32'h1F);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 12'hC6C, 16'h0104 | 16'(m));
			chk("mode", 32'({enc_run_isp, enc_run_cmd, enc_stop, cmd_picture_type, force_refresh}),
				32'({m == 0, m == 1, m == 2, m == 1, m == 0}));
		end
		bus(1'b1, 12'hC96, 16'h0070);
		chk("spc", 32'({half_rate_en, skip_one_frame, add_one_frame, deblock_en}), 32'hF);
		bus(1'b1, 12'hC96, 16'h000E);
		chk("spc0", 32'({half_rate_en, skip_one_frame, add_one_frame, deblock_en, dec_short_header_en,
			capture_irq_en}), 32'h03);
		bus(1'b1, 12'hC68, 16'h0001);
		chk("clr", 32'(hdr_flag_clear), 32'h1);
		bus(1'b1, 12'hC68, 16'h0000);
		chk("clr0", 32'(hdr_flag_clear), 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 12'hC66, 16'(1 << i));
			cause_sel <= ~4'(1 << i);
			#2;
			chk("irqoff", 32'(encode_irq), 32'h0);
			cause_sel <= 4'(1 << i);
			#2;
			chk("irqon", 32'(encode_irq), 32'h1);
		end
		// driver programs short header the way software must
		bus(1'b1, 12'hC56, 16'h0001);
		bus(1'b1, 12'hC58, 16'h0010);
		chk("shdr", 32'({enc_short_header, four_mv_en, restricted_mv_en}), 32'h5);
		// driver loads the recommended tolerances after reset
		bus(1'b1, 12'hC5A, 16'h0200);
		bus(1'b1, 12'hC5C, 16'h0081);
		bus(1'b1, 12'hC5E, 16'h0081);
		chk("toli", 32'(intra_tolerance), 32'h200);
		chk("tolfz", 32'({four_vector_tolerance, zero_vector_tolerance}), 32'h081081);
		// large encode picture with skip count zero before the first frame
		bus(1'b1, 12'hC60, 16'h8000);
		chk("big", 32'({large_picture, skip_frame_num}), 32'h40);
		test_done();
	end
endmodule : video_codec_control_regs_tb
`default_nettype wire
